// ==== logic/pscr_cfg.svh ====
// register offsets, field positions, reset values for the slot/power config bank
`ifndef PSCR_CFG_SVH
`define PSCR_CFG_SVH
`define PSCR_OFS_PWRCTL     8'h94
`define PSCR_OFS_SLOTID     8'hA0
`define PSCR_OFS_CLKCTL     8'hA4
`define PSCR_PS_D0          2'h0
`define PSCR_PS_D3          2'h3
`define PSCR_BIT_PME_EN     8
`define PSCR_BIT_PME_STS    15
`define PSCR_SI_CAP_ID      8'h04
`define PSCR_SI_NEXT_PTR    8'hB0
`define PSCR_CLK_STOP_CODE  2'h3
`define PSCR_SOFT_RST_LEN   4'h4
`endif

// ==== logic/pscr_pkg.sv ====
// types for the slot/power config bank
`default_nettype none
package pscr_pkg;
  // register bus request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } pscr_req_type;
  // soft reset sequencer states
  typedef enum logic [1:0] {
    PSCR_RUN,
    PSCR_SOFT_RESET
  } pscr_state_type;
endpackage : pscr_pkg
`default_nettype wire

// ==== logic/pscr_regs.sv ====
// power management, slot identification and slot clock enable registers
//
// Behaviour
// RULE_01: power state is a two-bit field in bits 1:0, 00 is D0, 11 is D3, reset 00.
// RULE_02: writes of code 01 or 10 to the power state are discarded.
// RULE_03: a write moving the power state from D3 to D0 starts an internal soft reset.
// RULE_04: bit 8 is a sticky power-event enable; while 0 the event pin never asserts.
// RULE_05: data select, data scale and the data byte always read zero.
// RULE_06: bridge support bits 22 and 23 read zero.
// RULE_07: slot-id slot_ident_cap_id reads 04h and is visible only when enabled by the load.
// RULE_08: slot-id next pointer reads B0h.
// RULE_09: slot number 20:16 and first-in-chassis 21 are read-write, reset zero; 23:22 zero.
// RULE_10: chassis number 31:24 is read-write, reset zero.
// RULE_11: each slot clock has a two-bit enable field at 1:0, 3:2, 5:4, 7:6.
// RULE_12: codes 00, 01, 10 keep a slot clock running; 11 stops it and holds it low.
// RULE_13: slot clock enables take effect only in forward bridge mode.
// RULE_14: the power event is generated without the bus clock, in D0, D3hot and D3cold. The code sets status and the pin only on mclk edges.
// RULE_15: writes to read-only or reserved bits have no effect.
`timescale 1ns/1ps
`default_nettype none
`include "pscr_cfg.svh"

module pscr_regs
  import pscr_pkg::*;
#(
  parameter int SLOTS = 4                      // number of slot clock outputs
) (
  input  wire logic             mclk,          // system clock, 100 MHz
  input  wire logic             sys_rst,       // synchronous reset, active high
  input  wire logic [7:0]       regAddr,       // register byte address
  input  wire logic [31:0]      regWdata,      // write data
  input  wire logic             regWr,         // write strobe
  input  wire logic             regRd,         // read strobe
  output logic      [31:0]      regRdata,      // read data, cycle after read strobe
  input  wire logic             slotIdEnable,  // slot-id capability enabled by config load
  input  wire logic             forwardMode,   // bridge in forward mode
  input  wire logic             powerEvent,    // internal wake event request
  input  wire logic [SLOTS-1:0] slotClockIn,   // free-running secondary clock source
  output logic                  power_event_out_n, // power event pin, active low
  output logic [SLOTS-1:0]      slotClockOut,  // gated slot clock pins
  output logic [1:0]            powerState,    // present power state
  output logic                  softReset      // internal device reset pulse, four cycles long
);

  // elaboration check: the clock control word holds four slot fields
  if (SLOTS < 1 || SLOTS > 4) begin : gBadSlots
    $error("SLOTS must be 1 to 4");
  end

  pscr_req_type req;
  pscr_state_type rstState;
  logic [3:0]   rstCount;
  logic         pmeEnable;
  logic         pmeStatus;
  logic [4:0]   slotNumber;
  logic         firstInChassis;
  logic [7:0]   chassisNumber;
  logic [7:0]   clkEnable;
  logic         next_softStart;

  // bundle the bus request
  assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

  // RULE_03 detect D3 to D0
  assign next_softStart = req.wr && (req.addr == `PSCR_OFS_PWRCTL)
                          && (powerState == `PSCR_PS_D3)
                          && (req.wdata[1:0] == `PSCR_PS_D0);

  // power state field
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      powerState <= `PSCR_PS_D0;
    end else if (req.wr && req.addr == `PSCR_OFS_PWRCTL) begin
      // RULE_01 RULE_02 accept D0/D3 only
      if (req.wdata[1:0] == `PSCR_PS_D0 || req.wdata[1:0] == `PSCR_PS_D3) begin
        powerState <= req.wdata[1:0];
      end
    end
  end

  // RULE_03 soft reset sequencer
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rstState  <= PSCR_RUN;
      rstCount  <= 4'h0;
      softReset <= 1'b0;
    end else begin
      case (rstState)
        PSCR_RUN: begin
          if (next_softStart) begin
            rstState  <= PSCR_SOFT_RESET;
            rstCount  <= `PSCR_SOFT_RST_LEN - 4'h1;
            softReset <= 1'b1;
          end
        end
        PSCR_SOFT_RESET: begin
          if (rstCount == 4'h0) begin
            rstState  <= PSCR_RUN;
            softReset <= 1'b0;
          end else begin
            rstCount <= rstCount - 4'h1;
          end
        end
        default: rstState <= PSCR_RUN;
      endcase
    end
  end

  // RULE_04 sticky enable and status, kept over soft reset
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pmeEnable <= 1'b0;
      pmeStatus <= 1'b0;
    end else begin
      if (req.wr && req.addr == `PSCR_OFS_PWRCTL) begin
        pmeEnable <= req.wdata[`PSCR_BIT_PME_EN];
      end
      // status set wins over write-one-to-clear
      if (powerEvent) begin
        pmeStatus <= 1'b1;
      end else if (req.wr && req.addr == `PSCR_OFS_PWRCTL
                   && req.wdata[`PSCR_BIT_PME_STS]) begin
        pmeStatus <= 1'b0;
      end
    end
  end

  // RULE_04 RULE_14 event pin, gated only by enable, in any power state
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      power_event_out_n <= 1'b1;
    end else begin
      power_event_out_n <= ~(pmeEnable && pmeStatus);
    end
  end

  // RULE_09 RULE_10 slot id fields, cleared by soft reset too
  always_ff @(posedge mclk) begin
    if (sys_rst || softReset) begin
      slotNumber     <= 5'h00;
      firstInChassis <= 1'b0;
      chassisNumber  <= 8'h00;
    end else if (req.wr && req.addr == `PSCR_OFS_SLOTID && slotIdEnable) begin
      slotNumber     <= req.wdata[20:16];
      firstInChassis <= req.wdata[21];
      chassisNumber  <= req.wdata[31:24];
    end
  end

  // RULE_11 slot clock enable fields
  always_ff @(posedge mclk) begin
    if (sys_rst || softReset) begin
      clkEnable <= 8'h00;
    end else if (req.wr && req.addr == `PSCR_OFS_CLKCTL) begin
      clkEnable <= req.wdata[7:0];
    end
  end

  // RULE_12 RULE_13 slot clock gating, only in forward mode
  always_ff @(posedge mclk) begin
    for (int i = 0; i < SLOTS; i++) begin
      if (sys_rst) begin
        slotClockOut[i] <= 1'b0;
      end else if (forwardMode && clkEnable[2*i +: 2] == `PSCR_CLK_STOP_CODE) begin
        slotClockOut[i] <= 1'b0;
      end else begin
        slotClockOut[i] <= slotClockIn[i];
      end
    end
  end

  // RULE_05 RULE_06 RULE_07 RULE_08 RULE_15 read mux, fixed fields zero
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      regRdata <= 32'h0000_0000;
    end else if (req.rd) begin
      if (req.addr == `PSCR_OFS_PWRCTL) begin
        regRdata <= {16'h0000, pmeStatus, 6'h00, pmeEnable, 6'h00, powerState};
      end else if (req.addr == `PSCR_OFS_SLOTID && slotIdEnable) begin
        regRdata <= {chassisNumber, 2'h0, firstInChassis, slotNumber,
                     `PSCR_SI_NEXT_PTR, `PSCR_SI_CAP_ID};
      end else if (req.addr == `PSCR_OFS_CLKCTL) begin
        regRdata <= {24'h000000, clkEnable};
      end else begin
        regRdata <= 32'h0000_0000;
      end
    end else begin
      regRdata <= 32'h0000_0000;
    end
  end

endmodule : pscr_regs
`default_nettype wire

// ==== sim/pscr_clk_src.sv ====
// free-running slot clock sources
`timescale 1ns/1ps
`default_nettype none
module pscr_clk_src (
  input  wire logic       mclk,     // system clock
  output var  logic [3:0] srcClock  // one divided clock a slot
);
  // counter: bit k toggles every 2^k cycles
  initial srcClock = 4'h0;
  always @(posedge mclk) srcClock <= srcClock + 4'h1;
endmodule : pscr_clk_src
`default_nettype wire

// ==== sim/pscr_regs_props.sv ====
// port assertions of the register bank
`timescale 1ns/1ps
`default_nettype none
module pscr_regs_props #(parameter int SLOTS = 4) (
  input wire logic             mclk,              // clock
  input wire logic             sys_rst,           // reset
  input wire logic [7:0]       regAddr,           // address
  input wire logic [31:0]      regWdata,          // write data
  input wire logic             regWr,             // write strobe
  input wire logic             regRd,             // read strobe
  input wire logic [31:0]      regRdata,          // read data
  input wire logic             slotIdEnable,      // slot-id shown
  input wire logic             forwardMode,       // forward mode
  input wire logic             power_event_out_n, // event pin
  input wire logic [SLOTS-1:0] slotClockOut,      // slot clocks
  input wire logic [1:0]       powerState,        // power state
  input wire logic             softReset          // soft reset
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  ps_legal_a: assert property (powerState[0] == powerState[1])
    else $error("power state code illegal");
  ps_write_a: assert property (regWr && regAddr == 8'h94 && regWdata[0] == regWdata[1]
    |=> powerState == $past(regWdata[1:0])) else $error("power state not taken");
  ps_discard_a: assert property (regWr && regAddr == 8'h94 && regWdata[0] != regWdata[1]
    |=> $stable(powerState)) else $error("bad state code taken");
  soft_rst_a: assert property ($past(powerState) == 2'h3 && powerState == 2'h0
    |-> softReset [*4] ##1 !softReset) else $error("soft reset wrong");
  pme_off_a: assert property (regWr && regAddr == 8'h94 && !regWdata[8]
    |-> ##2 power_event_out_n) else $error("event pin while disabled");
  pm_ro_a: assert property (regRd && regAddr == 8'h94 |=> regRdata[31:22] == 10'h0
    && regRdata[14:9] == 6'h0 && regRdata[7:2] == 6'h0) else $error("ro bits set");
  slot_id_a: assert property (regRd && regAddr == 8'hA0 && slotIdEnable
    |=> regRdata[23:0] ==? 24'h??B004) else $error("slot id header wrong");
  clk_stop_a: assert property (regWr && regAddr == 8'hA4 && regWdata[1:0] == 2'h3
    && forwardMode && !softReset |-> ##2 !slotClockOut[0])
    else $error("slot clock not held");
  cover property (softReset);
  cover property (!power_event_out_n);
  cover property (regRd && regAddr == 8'hA4);
endmodule : pscr_regs_props
bind pscr_regs pscr_regs_props #(.SLOTS(SLOTS)) u_props (.mclk(mclk), .sys_rst(sys_rst),
  .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
  .regRdata(regRdata), .slotIdEnable(slotIdEnable), .forwardMode(forwardMode),
  .power_event_out_n(power_event_out_n), .slotClockOut(slotClockOut),
  .powerState(powerState), .softReset(softReset));
`default_nettype wire

// ==== sim/pscr_regs_tb_top.sv ====
// self-checking bench of the register bank
`timescale 1ns/1ps
`default_nettype none
module pscr_regs_tb_top;
  logic        mclk, sys_rst, regWr, regRd, slotIdEnable, forwardMode, powerEvent, pmeN;
  logic        softReset;
  logic [1:0]  powerState;
  logic [7:0]  regAddr;
  logic [31:0] regWdata, regRdata, d;
  logic [3:0]  slotClockIn, slotClockOut, seen;
  int          err_total, tests_run, seed;
  pscr_regs dut (.mclk(mclk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .slotIdEnable(slotIdEnable),
    .forwardMode(forwardMode), .powerEvent(powerEvent), .slotClockIn(slotClockIn),
    .power_event_out_n(pmeN), .slotClockOut(slotClockOut), .powerState(powerState),
    .softReset(softReset));
  pscr_clk_src src (.mclk(mclk), .srcClock(slotClockIn));
  always #5 mclk = ~mclk;
  task chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= v;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 chk(regRdata, e);
  endtask : rd
  // pin level checked on the second falling clock edge after a cause
  task pin(input logic e);
    repeat (2) @(negedge mclk);
    chk({31'h0, pmeN}, {31'h0, e});
  endtask : pin
  // running slots seen high at least once in 16 cycles
  task obs(input logic [3:0] e);
    seen = 4'h0;
    repeat (16) @(negedge mclk) seen = seen | slotClockOut;
    chk({28'h0, seen}, {28'h0, e});
  endtask : obs
  function automatic logic [3:0] run(input logic [7:0] f);
    for (int k = 0; k < 4; k++) run[k] = ~&f[2*k +: 2];
  endfunction : run
  task summarize;
    if (err_total == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize
  initial begin
    {mclk, sys_rst, regWr, regRd, slotIdEnable, forwardMode, powerEvent} = 7'h40;
    {regAddr, regWdata, err_total, tests_run, seed} = {40'h0, 64'h0, 32'h6B81};
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(8'h94, 32'h0);
    wr(8'hA0, 32'hFFFFFFFF);
    rd(8'hA0, 32'h0);
    slotIdEnable <= 1'b1;
    rd(8'hA0, 32'h0000B004);
    wr(8'h94, 32'hFFFF7E01);
    rd(8'h94, 32'h0);
    wr(8'h94, 32'h3);
    wr(8'h94, 32'h2);
    rd(8'h94, 32'h3);
    powerEvent <= 1'b1;
    pin(1'b1);
    wr(8'h94, 32'h103);
    powerEvent <= 1'b0;
    pin(1'b0);
    wr(8'h94, 32'h8103);
    pin(1'b1);
    d = $random(seed);
    wr(8'hA0, d);
    rd(8'hA0, d & 32'hFF3F0000 | 32'hB004);
    wr(8'h94, 32'h0);
    @(negedge mclk) chk({31'h0, softReset}, 32'h1);
    rd(8'hA0, 32'hB004);
    repeat (4) @(posedge mclk);
    forwardMode <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? 32'hFF : $random(seed);
      wr(8'hA4, {24'h0, d[7:0]});
      rd(8'hA4, {24'h0, d[7:0]});
      obs(run(d[7:0]));
    end
    forwardMode <= 1'b0;
    obs(4'hF);
    summarize;
  end
  initial begin
    #100000;
    err_total++;
    summarize;
  end
endmodule : pscr_regs_tb_top
`default_nettype wire
